//--- rtl/trinary_remote_encoder.sv
`timescale 1ns/100ps
module trinary_remote_encoder
#(
    parameter int OSC_DIV = trinary_encoder_pkg::OSC_DIV,
    parameter int SLOT_TICKS = trinary_encoder_pkg::SLOT_TICKS,
    parameter int SHORT_TICKS = trinary_encoder_pkg::SHORT_TICKS,
    parameter int LONG_TICKS = trinary_encoder_pkg::LONG_TICKS
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic send_request_n,
    input wire logic send_request_n_oe,
    input wire logic [4:0] address_digit_inputs,
    input wire logic [3:0] shared_addr_data_inputs,
    output logic [8:0] digitPullOut,
    output logic [8:0] digitPullOe,
    output logic serialOut,
    output logic oscRunning
);

    localparam int NDIG = trinary_encoder_pkg::DIGIT_COUNT;
    localparam int SENSE = trinary_encoder_pkg::SENSE_TICKS;

    // Encoder phases, one-hot
    typedef enum logic [5:0]
    {
        ST_IDLE = 6'h01,
        ST_PULL_UP = 6'h02,
        ST_PULL_DOWN = 6'h04,
        ST_SEND = 6'h08,
        ST_GAP = 6'h10,
        ST_CHECK = 6'h20
    } phase_t;

    phase_t phase_reg;
    // Request level with the pin pulled up
    logic requestLevel;
    // Synchroniser stages for request
    logic [2:0] reqSync_reg;
    // Filtered active request
    logic reqActive_reg;
    // Latched request that survives a short pulse
    logic reqPending_reg;
    // Oscillator divider
    logic [15:0] divCount_reg;
    // One-cycle oscillator tick
    logic oscTick;
    // Tick counter inside a phase
    logic [15:0] tickCount_reg;
    // Digit index being sent
    logic [3:0] digitIdx_reg;
    // Which half of the digit, 0 or 1
    logic halfIdx_reg;
    // Word index in sequence
    logic wordIdx_reg;
    // Sense strobes
    logic sampleUp;
    logic sampleDown;
    // Sensed digits
    logic [1:0] digitCodes [NDIG];
    // Pins in send order: address first
    logic [8:0] pinLevels;
    // Long pulse needed for current slot
    logic slotLong;
    // Current digit code
    logic [1:0] curDigit;
    // High-time limit of the current slot
    logic [15:0] highTicks;

    ////////////////////////////////////////////////////////////////////////
    // Undriven request pin reads high
    assign requestLevel = send_request_n_oe ? send_request_n : 1'b1;
    assign pinLevels = {shared_addr_data_inputs, address_digit_inputs};

    // Request synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            reqSync_reg <= 3'h7;
        else
            reqSync_reg <= {reqSync_reg[1:0], requestLevel};
    end

    // Change counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            reqActive_reg <= 1'b0;
        else if (reqSync_reg[1] == reqSync_reg[2])
            reqActive_reg <= !reqSync_reg[2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Holds a short request until the sequence starts
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            reqPending_reg <= 1'b0;
        else if (phase_reg != ST_IDLE)
            reqPending_reg <= 1'b0;
        else if (reqActive_reg)
            reqPending_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator divider, runs only out of idle
    assign oscRunning = (phase_reg != ST_IDLE);
    assign oscTick = oscRunning && (divCount_reg == 16'(OSC_DIV - 1));

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !oscRunning)
            divCount_reg <= 16'h0000;
        else if (oscTick)
            divCount_reg <= 16'h0000;
        else
            divCount_reg <= divCount_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Nine sensing cells
    generate
        for (genvar i = 0; i < NDIG; i++)
        begin : g_sense
            trinary_digit_sense u_sense
            (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .pinLevel(pinLevels[i]),
                .sampleUp(sampleUp),
                .sampleDown(sampleDown),
                .digitCode(digitCodes[i])
            );
        end
    endgenerate

    // Sample at the end of each pull phase
    assign sampleUp = oscTick && (phase_reg == ST_PULL_UP)
        && (tickCount_reg == 16'(SENSE - 1));
    assign sampleDown = oscTick && (phase_reg == ST_PULL_DOWN)
        && (tickCount_reg == 16'(SENSE - 1));

    // Weak pull drive: high then low during sensing
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            digitPullOut <= 9'h000;
            digitPullOe <= 9'h000;
        end
        else if (phase_reg == ST_PULL_UP)
        begin
            digitPullOut <= 9'h1FF;
            digitPullOe <= 9'h1FF;
        end
        else if (phase_reg == ST_PULL_DOWN)
        begin
            digitPullOut <= 9'h000;
            digitPullOe <= 9'h1FF;
        end
        else
        begin
            digitPullOut <= 9'h000;
            digitPullOe <= 9'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse shape for current slot
    always_comb
    begin
        curDigit = digitCodes[digitIdx_reg < 4'(NDIG) ? digitIdx_reg : 4'h0];
        case (curDigit)
            trinary_encoder_pkg::DIGIT_HIGH: slotLong = 1'b1;
            trinary_encoder_pkg::DIGIT_OPEN: slotLong = !halfIdx_reg;
            default: slotLong = 1'b0;
        endcase
        highTicks = slotLong ? 16'(LONG_TICKS) : 16'(SHORT_TICKS);
    end

    // Serial output from a flop
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            serialOut <= 1'b0;
        else if (phase_reg == ST_SEND)
            serialOut <= (tickCount_reg < highTicks);
        else
            serialOut <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            phase_reg <= ST_IDLE;
            tickCount_reg <= 16'h0000;
            digitIdx_reg <= 4'h0;
            halfIdx_reg <= 1'b0;
            wordIdx_reg <= 1'b0;
        end
        else
        begin
            case (phase_reg)
                ST_IDLE:
                begin
                    tickCount_reg <= 16'h0000;
                    digitIdx_reg <= 4'h0;
                    halfIdx_reg <= 1'b0;
                    wordIdx_reg <= 1'b0;
                    if (reqActive_reg || reqPending_reg)
                        phase_reg <= ST_PULL_UP;
                end
                ST_PULL_UP:
                begin
                    if (oscTick)
                    begin
                        if (tickCount_reg == 16'(SENSE - 1))
                        begin
                            tickCount_reg <= 16'h0000;
                            phase_reg <= ST_PULL_DOWN;
                        end
                        else
                            tickCount_reg <= tickCount_reg + 16'h0001;
                    end
                end
                ST_PULL_DOWN:
                begin
                    if (oscTick)
                    begin
                        if (tickCount_reg == 16'(SENSE - 1))
                        begin
                            tickCount_reg <= 16'h0000;
                            phase_reg <= ST_SEND;
                        end
                        else
                            tickCount_reg <= tickCount_reg + 16'h0001;
                    end
                end
                ST_SEND:
                begin
                    if (oscTick)
                    begin
                        if (tickCount_reg == 16'(SLOT_TICKS - 1))
                        begin
                            tickCount_reg <= 16'h0000;
                            halfIdx_reg <= !halfIdx_reg;
                            if (halfIdx_reg)
                            begin
                                // Next digit or end of word
                                if (digitIdx_reg == 4'(NDIG - 1))
                                begin
                                    digitIdx_reg <= 4'h0;
                                    phase_reg <= wordIdx_reg ? ST_CHECK : ST_GAP;
                                end
                                else
                                    digitIdx_reg <= digitIdx_reg + 4'h1;
                            end
                        end
                        else
                            tickCount_reg <= tickCount_reg + 16'h0001;
                    end
                end
                ST_GAP:
                begin
                    // Quiet for three data periods
                    if (oscTick)
                    begin
                        if (tickCount_reg == 16'(trinary_encoder_pkg::GAP_PERIODS
                            * 2 * SLOT_TICKS - 1))
                        begin
                            tickCount_reg <= 16'h0000;
                            wordIdx_reg <= 1'b1;
                            phase_reg <= ST_SEND;
                        end
                        else
                            tickCount_reg <= tickCount_reg + 16'h0001;
                    end
                end
                ST_CHECK:
                begin
                    // Sequence done; repeat while held, else halt
                    wordIdx_reg <= 1'b0;
                    if (reqActive_reg)
                        phase_reg <= ST_PULL_UP;
                    else
                        phase_reg <= ST_IDLE;
                end
                default:
                    phase_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

//--- rtl/trinary_encoder_pkg.sv
package trinary_encoder_pkg;

    // Number of digits in one word
    localparam int DIGIT_COUNT = 9;
    // Address-only digits go first
    localparam int ADDR_DIGITS = 5;
    // Shared address/data digits follow
    localparam int SHARED_DIGITS = 4;
    // Words in one sequence
    localparam int WORDS_PER_SEQ = 2;
    // Idle data periods between the two words
    localparam int GAP_PERIODS = 3;

    // Oscillator period in ns (default link rate)
    localparam int OSC_PERIOD_NS = 10000;
    // System clock period in ns
    localparam int SYS_PERIOD_NS = 10;
    // System cycles per oscillator tick, rounded down, at least one
    localparam int OSC_DIV = (OSC_PERIOD_NS / SYS_PERIOD_NS) < 1 ? 1
        : (OSC_PERIOD_NS / SYS_PERIOD_NS);

    // Oscillator ticks per half digit (one pulse slot)
    localparam int SLOT_TICKS = 8;
    // Short pulse high time in ticks
    localparam int SHORT_TICKS = 2;
    // Long pulse high time in ticks
    localparam int LONG_TICKS = 6;
    // Ticks the sense pull is held before sampling
    localparam int SENSE_TICKS = 2;

    // Trinary digit codes
    localparam logic [1:0] DIGIT_LOW = 2'h0;
    localparam logic [1:0] DIGIT_HIGH = 2'h1;
    localparam logic [1:0] DIGIT_OPEN = 2'h2;

endpackage

//--- rtl/trinary_digit_sense.sv
`timescale 1ns/100ps
// Classifies one pin from its two samples under weak pull-up and pull-down
module trinary_digit_sense
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pinLevel,
    input wire logic sampleUp,
    input wire logic sampleDown,
    output logic [1:0] digitCode
);

    // Three-stage input sync
    logic [2:0] syncPipe_reg;
    // Level seen under pull-up
    logic upLevel_reg;
    // Stable level from stages two and three
    logic stableLevel;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            syncPipe_reg <= 3'h0;
        else
            syncPipe_reg <= {syncPipe_reg[1:0], pinLevel};
    end

    // Stages two and three agree before a change counts
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            stableLevel <= 1'b0;
        else if (syncPipe_reg[1] == syncPipe_reg[2])
            stableLevel <= syncPipe_reg[2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture level under pull-up
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            upLevel_reg <= 1'b0;
        else if (sampleUp)
            upLevel_reg <= stableLevel;
    end

    // Classify after the pull-down sample
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            digitCode <= trinary_encoder_pkg::DIGIT_LOW;
        else if (sampleDown)
        begin
            // Follows both pulls: open; else fixed level
            if (upLevel_reg && !stableLevel)
                digitCode <= trinary_encoder_pkg::DIGIT_OPEN;
            else if (upLevel_reg)
                digitCode <= trinary_encoder_pkg::DIGIT_HIGH;
            else
                digitCode <= trinary_encoder_pkg::DIGIT_LOW;
        end
    end

endmodule

//--- test/trinary_remote_encoder_properties.sv
`timescale 1ns/100ps
// Port-level checks on the encoder top
module trinary_remote_encoder_properties
#(
    parameter int OSC_DIV = 2,
    parameter int SLOT_TICKS = 8,
    parameter int SHORT_TICKS = 2,
    parameter int LONG_TICKS = 6
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic send_request_n,
    input wire logic send_request_n_oe,
    input wire logic [4:0] address_digit_inputs,
    input wire logic [3:0] shared_addr_data_inputs,
    input wire logic [8:0] digitPullOut,
    input wire logic [8:0] digitPullOe,
    input wire logic serialOut,
    input wire logic oscRunning
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // High run length, cycles since last rise, rhythm valid flag
    logic [15:0] hiCnt;
    logic [15:0] riseCnt;
    logic armed;
    logic reqLow;
    assign reqLow = send_request_n_oe && !send_request_n;
    ////////////////////////////////
    // Run-length helpers; rhythm disarmed while idle or sensing
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            hiCnt <= 16'h0000;
            riseCnt <= 16'h0000;
            armed <= 1'b0;
        end
        else
        begin
            hiCnt <= serialOut ? hiCnt + 16'h0001 : 16'h0000;
            riseCnt <= $rose(serialOut) ? 16'h0001 : riseCnt + 16'h0001;
            armed <= (!oscRunning || digitPullOe != 9'h000) ? 1'b0
                : ($rose(serialOut) ? 1'b1 : armed);
        end
    end
    ////////////////////////////////
    a_idle_quiet: assert property (!oscRunning && !$past(oscRunning) |-> !serialOut)
        else $error("serial output active while idle");
    a_idle_nopull: assert property (!oscRunning |-> digitPullOe == 9'h000)
        else $error("pull enabled while idle");
    a_start_bound: assert property ($rose(reqLow) && !oscRunning |-> ##[1:8] oscRunning)
        else $error("oscillator did not start on request");
    a_sense_updown: assert property ($rose(digitPullOe[0]) |->
        (digitPullOut[0] && digitPullOe[0]) [*3] ##[1:300] (digitPullOe[0] && !digitPullOut[0]))
        else $error("sense pull not high then low");
    a_sense_silent: assert property (digitPullOe != 9'h000 |-> !serialOut)
        else $error("pulse during sensing");
    a_pulse_width: assert property ($fell(serialOut) |->
        hiCnt == SHORT_TICKS * OSC_DIV || hiCnt == LONG_TICKS * OSC_DIV)
        else $error("pulse width not short or long");
    a_slot_rhythm: assert property ($rose(serialOut) && armed |-> riseCnt == SLOT_TICKS * OSC_DIV
        || riseCnt == SLOT_TICKS * OSC_DIV * (1 + 2 * trinary_encoder_pkg::GAP_PERIODS))
        else $error("slot spacing wrong");
    a_stays_off: assert property ((!oscRunning && !reqLow) [*6] |=> !oscRunning)
        else $error("oscillator started without request");
    c_long_pulse: cover property ($fell(serialOut) && hiCnt == LONG_TICKS * OSC_DIV);
    c_word_gap: cover property ($rose(serialOut) && armed && riseCnt > SLOT_TICKS * OSC_DIV);
    c_osc_start: cover property ($rose(oscRunning));
endmodule

bind trinary_remote_encoder trinary_remote_encoder_properties
#(
    .OSC_DIV(OSC_DIV),
    .SLOT_TICKS(SLOT_TICKS),
    .SHORT_TICKS(SHORT_TICKS),
    .LONG_TICKS(LONG_TICKS)
)
props_u
(
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .send_request_n(send_request_n),
    .send_request_n_oe(send_request_n_oe),
    .address_digit_inputs(address_digit_inputs),
    .shared_addr_data_inputs(shared_addr_data_inputs),
    .digitPullOut(digitPullOut),
    .digitPullOe(digitPullOe),
    .serialOut(serialOut),
    .oscRunning(oscRunning)
);

//--- test/serial_decoder_model.sv
`timescale 1ns/100ps
// Receiving end: sorts pulses into short or long, collects words
module serial_decoder_model
#(
    parameter int OSC_DIV = 2
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serialLine,
    output logic [7:0] wordsSeen,
    output logic [17:0] firstWord,
    output logic [17:0] lastWord,
    output logic [15:0] gapLow
);
    // Long if wider than halfway between the two widths
    localparam int LONG_MIN = (trinary_encoder_pkg::SHORT_TICKS
        + trinary_encoder_pkg::LONG_TICKS) * OSC_DIV / 2;
    localparam int SLOT = trinary_encoder_pkg::SLOT_TICKS * OSC_DIV;
    logic [15:0] hiCnt;
    logic [15:0] loCnt;
    logic [4:0] bitCnt;
    logic [17:0] shiftWord;
    logic lineReg;
    ////////////////////////////////
    // Pulse measure and word assembly
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            hiCnt <= 16'h0000;
            loCnt <= 16'h0000;
            bitCnt <= 5'h00;
            shiftWord <= 18'h00000;
            lineReg <= 1'b0;
            wordsSeen <= 8'h00;
            firstWord <= 18'h00000;
            lastWord <= 18'h00000;
            gapLow <= 16'h0000;
        end
        else
        begin
            lineReg <= serialLine;
            hiCnt <= serialLine ? hiCnt + 16'h0001 : 16'h0000;
            loCnt <= serialLine ? 16'h0000 : loCnt + 16'h0001;
            // Long quiet run before a rise is the word gap
            if (serialLine && !lineReg && loCnt > SLOT)
                gapLow <= loCnt;
            // Falling edge ends a pulse
            if (!serialLine && lineReg)
            begin
                shiftWord[bitCnt] <= hiCnt > LONG_MIN;
                bitCnt <= (bitCnt == 5'h11) ? 5'h00 : bitCnt + 5'h01;
                if (bitCnt == 5'h11)
                begin
                    // First word of a pair kept apart from the second
                    lastWord <= {hiCnt > LONG_MIN, shiftWord[16:0]};
                    if (!wordsSeen[0])
                        firstWord <= {hiCnt > LONG_MIN, shiftWord[16:0]};
                    wordsSeen <= wordsSeen + 8'h01;
                end
            end
        end
    end
endmodule

//--- test/trinary_remote_encoder_bench.sv
`timescale 1ns/100ps
module trinary_remote_encoder_bench;
    localparam int DIV = 4;
    localparam int SLOT = trinary_encoder_pkg::SLOT_TICKS * DIV;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic reqLvl = 1'b1;
    logic reqOe = 1'b0;
    logic toggle = 1'b0;
    logic [17:0] modes = 18'h00000;
    logic [8:0] pinLvl;
    logic [8:0] pullOut;
    logic [8:0] pullOe;
    logic serialOut;
    logic oscRunning;
    logic [7:0] wordsSeen;
    logic [17:0] firstWord;
    logic [17:0] lastWord;
    logic [15:0] gapLow;
    int n_fail = 0;
    int tests_run = 0;
    // External clock source replaces the oscillator
    always #5 clk_sys = ~clk_sys;
    // Undriven lines show a changing pattern
    always @(posedge clk_sys) toggle <= ~toggle;
    // Pin level: hard drive wins, open pin follows the weak pull
    always_comb
    begin
        for (int i = 0; i < 9; i++)
        begin
            case (modes[2*i +: 2])
                trinary_encoder_pkg::DIGIT_LOW: pinLvl[i] = 1'b0;
                trinary_encoder_pkg::DIGIT_HIGH: pinLvl[i] = 1'b1;
                default: pinLvl[i] = pullOe[i] ? pullOut[i] : toggle;
            endcase
        end
    end
    trinary_remote_encoder #(.OSC_DIV(DIV)) dut_u
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .send_request_n(reqOe ? reqLvl : toggle),
        .send_request_n_oe(reqOe),
        .address_digit_inputs(pinLvl[4:0]),
        .shared_addr_data_inputs(pinLvl[8:5]),
        .digitPullOut(pullOut),
        .digitPullOe(pullOe),
        .serialOut(serialOut),
        .oscRunning(oscRunning)
    );
    serial_decoder_model #(.OSC_DIV(DIV)) model_u
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .serialLine(serialOut),
        .wordsSeen(wordsSeen),
        .firstWord(firstWord),
        .lastWord(lastWord),
        .gapLow(gapLow)
    );
    ////////////////////////////////
    // Pulse kinds per digit: low 0,0; high 1,1; open 1,0
    function automatic logic [17:0] exp_word(input logic [17:0] m);
        logic [17:0] w;
        w = 18'h00000;
        for (int d = 0; d < 9; d++)
        begin
            w[2*d] = m[2*d +: 2] != trinary_encoder_pkg::DIGIT_LOW;
            w[2*d+1] = m[2*d +: 2] == trinary_encoder_pkg::DIGIT_HIGH;
        end
        return w;
    endfunction
    // Quiet cycles: tail of last slot plus the idle periods
    function automatic int exp_gap(input logic [17:0] m);
        int hi;
        hi = exp_word(m) >> 17 ? trinary_encoder_pkg::LONG_TICKS : trinary_encoder_pkg::SHORT_TICKS;
        return SLOT - hi * DIV + trinary_encoder_pkg::GAP_PERIODS * 2 * SLOT;
    endfunction
    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        tests_run++;
        if (expv !== got)
        begin
            $display("[FAIL] %s expected %0h seen %0h", what, expv, got);
            n_fail++;
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait on the oscillator flag
    task automatic wait_osc(input logic lvl, input int limit);
        int k;
        k = 0;
        while (oscRunning !== lvl && k < limit)
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        check("oscRunning wait", lvl, oscRunning);
        if (k == limit)
            complete_run();
    endtask
    ////////////////////////////////
    // Undriven request must read inactive: nothing moves
    task automatic t_idle();
        int seen;
        seen = 0;
        repeat (300)
        begin
            @(posedge clk_sys);
            #1;
            seen += (serialOut !== 1'b0) || (oscRunning !== 1'b0) || (pullOe !== 9'h000);
        end
        check("idle activity", 0, seen);
    endtask
    // Brief request pulse gives exactly one two-word sequence
    task automatic t_pulse(input logic [17:0] m);
        int w0;
        @(posedge clk_sys) modes <= m;
        w0 = wordsSeen;
        @(posedge clk_sys) reqOe <= 1'b1;
        reqLvl <= 1'b0;
        repeat (5) @(posedge clk_sys);
        reqLvl <= 1'b1;
        wait_osc(1'b1, 20);
        wait_osc(1'b0, 4000);
        repeat (2) @(posedge clk_sys);
        check("words per request", 2, wordsSeen - w0);
        check("first word", exp_word(m), firstWord);
        check("second word", exp_word(m), lastWord);
        check("gap low cycles", exp_gap(m), gapLow);
    endtask
    // Held request repeats; release mid-sequence finishes the pair
    task automatic t_hold(input logic [17:0] m);
        int w0;
        int k;
        k = 0;
        @(posedge clk_sys) modes <= m;
        w0 = wordsSeen;
        @(posedge clk_sys) reqLvl <= 1'b0;
        while (wordsSeen - w0 < 5 && k < 8000)
        begin
            @(posedge clk_sys);
            k++;
        end
        check("words while held", 5, wordsSeen - w0);
        if (k == 8000)
            complete_run();
        reqLvl <= 1'b1;
        wait_osc(1'b0, 4000);
        repeat (2) @(posedge clk_sys);
        check("words after release", 6, wordsSeen - w0);
        check("repeated word", exp_word(m), lastWord);
    endtask
    ////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_idle();
        t_pulse(18'h06864);
        t_pulse(18'h18609);
        t_hold(18'h2AAAA);
        complete_run();
    end
endmodule
